/* logic/ecl_ctrl.sv */
// single-pin led current step and pwm control with charge pump mode policy
// Functional notes
// RULE1 - each rising edge on the control pin adds one to the step count
// RULE2 - count applies to sinks only after pin stays high for the latch pause; the code applies code 1 at once on the first edge from shutdown
// RULE3 - pin low beyond off timeout shuts down and clears step register
// RULE4 - first rising edge from shutdown turns on at full scale, code 1
// RULE5 - further edges lower current; 16-level code equals edge count
// RULE6 - 8-level variant uses codes 1 to 8, 8 is lowest
// RULE7 - 4-level variant uses codes 1 to 4, 4 is lowest
// RULE8 - host keeps edge rate at or below 1 MHz
// RULE9 - serial variants leave 2x mode once supply is sufficient again
// RULE10 - pwm variant stays latched in 2x mode once entered
// RULE11 - pwm pin low for 1 ms clears the 2x latch
// RULE12 - pwm pin low for 1 ms enters low-power shutdown
// RULE13 - pwm variant sinks conduct while the pin is high
// RULE14 - high pwm pin enables the device from shutdown
// RULE15 - host low pulses in a burst last 0.3 to 75 us
// RULE16 - pwm sinks turn on about 2 us after pin rises
// RULE17 - edges past the last step hold the lowest-current code
// RULE18 - a parameter selects 16, 8, 4 level serial or pwm variant
`timescale 1ns/10ps
`include "ecl_cfg.svh"
module ecl_ctrl
  import ecl_pkg::*;
#(
  parameter ecl_variant_e VARIANT = ECL_VAR_STEP16,
  parameter int LAT_CYC = `ECL_LAT_CYC,
  parameter int OFF_CYC = `ECL_OFF_CYC,
  parameter int PWM_OFF_CYC = `ECL_PWM_OFF_CYC
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic ctrl_pin,
  input wire logic supply_low,
  output logic [`ECL_STEP_W-1:0] step_code,
  output logic [`ECL_SINKS-1:0] led_sink_outputs,
  output logic pump_2x,
  output logic active
);

  // ****************************************
  // constants and helpers
  // ****************************************
  localparam int PWM_ON_CYC = `ECL_PWM_ON_CYC;
  localparam bit IS_PWM = (VARIANT == ECL_VAR_PWM); // RULE18

  function automatic ecl_step_t last_step(input ecl_variant_e v);
    case (v)
      ECL_VAR_STEP8: last_step = `ECL_LEVELS_8;
      ECL_VAR_STEP4: last_step = `ECL_LEVELS_4;
      default: last_step = `ECL_LEVELS_16;
    endcase
  endfunction

  localparam ecl_step_t LAST = last_step(VARIANT);

  // ****************************************
  // pin sync, edge detect and level timer
  // ****************************************
  logic pin_s;
  logic pin_d_reg;
  logic pin_d_next;
  logic rise;
  logic fall;
  logic [`ECL_CNT_W-1:0] level_cnt;

  ecl_sync u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .din(ctrl_pin),
    .dout(pin_s)
  );

  assign rise = pin_s & ~pin_d_reg;
  assign fall = ~pin_s & pin_d_reg;

  ecl_timer u_timer (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .restart(rise | fall),
    .count(level_cnt)
  );

  logic low_off;
  logic high_lat;
  logic pwm_low_off;
  logic pwm_on_ok;
  // edge cycle still holds the old level's count
  assign low_off = ~pin_s & ~fall & (level_cnt >= `ECL_CNT_W'(OFF_CYC));
  assign high_lat = pin_s & ~rise & (level_cnt >= `ECL_CNT_W'(LAT_CYC));
  assign pwm_low_off = ~pin_s & ~fall & (level_cnt >= `ECL_CNT_W'(PWM_OFF_CYC));
  assign pwm_on_ok = pin_s & ~rise & (level_cnt >= `ECL_CNT_W'(PWM_ON_CYC));

  // ****************************************
  // control state
  // ****************************************
  ecl_state_e state_reg;
  ecl_state_e state_next;
  ecl_step_t count_reg;
  ecl_step_t count_next;
  ecl_step_t step_reg;
  ecl_step_t step_next;
  logic [`ECL_SINKS-1:0] sink_reg;
  logic [`ECL_SINKS-1:0] sink_next;
  logic pump_reg;
  logic pump_next;
  logic active_reg;
  logic active_next;

  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    step_next = step_reg;
    pump_next = pump_reg;
    pin_d_next = ce ? pin_s : pin_d_reg;
    if (ce)
    begin
      if (!IS_PWM)
      begin
        case (state_reg)
          ECL_ST_OFF:
          begin
            if (rise)
            begin
              count_next = `ECL_STEP_FULL; // RULE4
              step_next = `ECL_STEP_FULL; // RULE4
              state_next = ECL_ST_COUNT;
            end
          end
          ECL_ST_COUNT, ECL_ST_RUN:
          begin
            if (low_off)
            begin
              state_next = ECL_ST_OFF; // RULE3
              count_next = `ECL_STEP_OFF; // RULE3
              step_next = `ECL_STEP_OFF; // RULE3
            end
            else if (rise)
            begin
              state_next = ECL_ST_COUNT;
              if (state_reg == ECL_ST_RUN)
                count_next = `ECL_STEP_FULL; // RULE1
              else if (count_reg < LAST)
                count_next = count_reg + `ECL_STEP_W'(1); // RULE1 RULE5 RULE6 RULE7
              else
                count_next = LAST; // RULE17
            end
            else if (high_lat && state_reg == ECL_ST_COUNT)
            begin
              step_next = count_reg; // RULE2
              state_next = ECL_ST_RUN;
            end
          end
          default: state_next = ECL_ST_OFF;
        endcase
        pump_next = active_reg & supply_low; // RULE9
      end
      else
      begin
        case (state_reg)
          ECL_ST_OFF:
          begin
            if (pin_s)
            begin
              state_next = ECL_ST_RUN; // RULE14
              step_next = `ECL_STEP_FULL;
            end
          end
          default:
          begin
            if (pwm_low_off)
            begin
              state_next = ECL_ST_OFF; // RULE12
              step_next = `ECL_STEP_OFF;
            end
          end
        endcase
        if (pwm_low_off)
          pump_next = 1'b0; // RULE11
        else if (state_reg != ECL_ST_OFF && supply_low)
          pump_next = 1'b1; // RULE10
      end
    end
  end

  always_comb
  begin
    if (IS_PWM)
      sink_next = {`ECL_SINKS{pwm_on_ok & (state_reg != ECL_ST_OFF)}}; // RULE13 RULE16
    else
      sink_next = {`ECL_SINKS{step_reg != `ECL_STEP_OFF}};
    active_next = (state_next != ECL_ST_OFF);
    if (!ce)
    begin
      sink_next = sink_reg;
      active_next = active_reg;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= ECL_ST_OFF;
      count_reg <= `ECL_STEP_OFF;
      step_reg <= `ECL_STEP_OFF;
      sink_reg <= '0;
      pump_reg <= 1'b0;
      active_reg <= 1'b0;
      pin_d_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      step_reg <= step_next;
      sink_reg <= sink_next;
      pump_reg <= pump_next;
      active_reg <= active_next;
      pin_d_reg <= pin_d_next;
    end
  end

  assign step_code = step_reg;
  assign led_sink_outputs = sink_reg;
  assign pump_2x = pump_reg;
  assign active = active_reg;

  // ****************************************
  // checks
  // ****************************************
  property p_count_sat;
    @(posedge mclk) disable iff (!nrst) count_reg <= LAST;
  endproperty
  a_count_sat: assert property (p_count_sat) else $error("step count beyond last step"); // RULE17

  property p_first_edge;
    @(posedge mclk) disable iff (!nrst)
      (!IS_PWM && ce && state_reg == ECL_ST_OFF && rise) |=> (count_reg == `ECL_STEP_FULL);
  endproperty
  a_first_edge: assert property (p_first_edge) else $error("first edge not full scale"); // RULE4

  property p_off_clear;
    @(posedge mclk) disable iff (!nrst)
      (!IS_PWM && ce && low_off) |=> (step_reg == `ECL_STEP_OFF && state_reg == ECL_ST_OFF);
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("low timeout did not clear step"); // RULE3

  property p_step_stable;
    @(posedge mclk) disable iff (!nrst)
      (!IS_PWM && $changed(step_reg))
        |-> ($past(high_lat) || $past(low_off) || ($past(state_reg) == ECL_ST_OFF));
  endproperty
  a_step_stable: assert property (p_step_stable) else $error("step applied before latch pause"); // RULE2

  property p_edge_count;
    @(posedge mclk) disable iff (!nrst)
      (!IS_PWM && ce && state_reg == ECL_ST_COUNT && rise && !low_off && count_reg < LAST)
        |=> count_reg == $past(count_reg) + `ECL_STEP_W'(1);
  endproperty
  a_edge_count: assert property (p_edge_count) else $error("edge not counted"); // RULE1

  property p_pwm_latch;
    @(posedge mclk) disable iff (!nrst)
      (IS_PWM && pump_reg && !pwm_low_off) |=> pump_reg;
  endproperty
  a_pwm_latch: assert property (p_pwm_latch) else $error("2x latch dropped"); // RULE10

  property p_pwm_clear;
    @(posedge mclk) disable iff (!nrst)
      (IS_PWM && ce && pwm_low_off) |=> (!pump_reg && state_reg == ECL_ST_OFF);
  endproperty
  a_pwm_clear: assert property (p_pwm_clear) else $error("1 ms low did not shut down"); // RULE11

  property p_serial_pump;
    @(posedge mclk) disable iff (!nrst)
      (!IS_PWM && ce && !supply_low) |=> !pump_reg;
  endproperty
  a_serial_pump: assert property (p_serial_pump) else $error("2x held with good supply"); // RULE9

  property p_pwm_sink_low;
    @(posedge mclk) disable iff (!nrst)
      (IS_PWM && ce && !pin_s) |=> (led_sink_outputs == '0);
  endproperty
  a_pwm_sink_low: assert property (p_pwm_sink_low) else $error("sinks on while pin low"); // RULE13

  property p_pwm_on_delay;
    @(posedge mclk) disable iff (!nrst)
      (IS_PWM && ce && pin_s && !rise && level_cnt < `ECL_CNT_W'(PWM_ON_CYC)) |=> (led_sink_outputs == '0);
  endproperty
  a_pwm_on_delay: assert property (p_pwm_on_delay) else $error("sinks on before turn-on delay"); // RULE16

  property p_latch_apply;
    @(posedge mclk) disable iff (!nrst)
      (!IS_PWM && ce && state_reg == ECL_ST_COUNT && high_lat)
        |=> (step_reg == $past(count_reg) && state_reg == ECL_ST_RUN);
  endproperty
  a_latch_apply: assert property (p_latch_apply) else $error("latch pause did not apply count"); // RULE2

  property p_pwm_wake;
    @(posedge mclk) disable iff (!nrst)
      (IS_PWM && ce && state_reg == ECL_ST_OFF && pin_s) |=> (active && step_code == `ECL_STEP_FULL);
  endproperty
  a_pwm_wake: assert property (p_pwm_wake) else $error("high pin did not wake device"); // RULE14
endmodule

/* logic/ecl_cfg.svh */
// timing and field constants for the edge count led current control block
`ifndef ECL_CFG_SVH
`define ECL_CFG_SVH
`define ECL_CLK_PERIOD_NS 10
`define ECL_T_LAT_US 500
`define ECL_T_OFF_US 500
`define ECL_T_PWM_OFF_MS 1
`define ECL_T_PWM_ON_US 2
`define ECL_LAT_CYC ((`ECL_T_LAT_US * 1000) / `ECL_CLK_PERIOD_NS)
`define ECL_OFF_CYC ((`ECL_T_OFF_US * 1000) / `ECL_CLK_PERIOD_NS)
`define ECL_PWM_OFF_CYC ((`ECL_T_PWM_OFF_MS * 1000000) / `ECL_CLK_PERIOD_NS)
`define ECL_PWM_ON_CYC ((`ECL_T_PWM_ON_US * 1000) / `ECL_CLK_PERIOD_NS)
`define ECL_CNT_W 20
`define ECL_STEP_W 5
`define ECL_STEP_OFF 5'h00
`define ECL_STEP_FULL 5'h01
`define ECL_LEVELS_16 5'h10
`define ECL_LEVELS_8 5'h08
`define ECL_LEVELS_4 5'h04
`define ECL_SINKS 3
`endif

/* logic/ecl_pkg.sv */
// types for the edge count led current control block
package ecl_pkg;
  typedef enum {ECL_VAR_STEP16, ECL_VAR_STEP8, ECL_VAR_STEP4, ECL_VAR_PWM} ecl_variant_e;
  typedef enum {ECL_ST_OFF, ECL_ST_COUNT, ECL_ST_RUN} ecl_state_e;
  typedef logic [4:0] ecl_step_t;
endpackage

/* logic/ecl_sync.sv */
// two flip-flop synchroniser for the control pin
`timescale 1ns/10ps
module ecl_sync
  import ecl_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic din,
  output logic dout
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  always_comb
  begin
    meta_next = ce ? din : meta_reg;
    sync_next = ce ? meta_reg : sync_reg;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign dout = sync_reg;
endmodule

/* logic/ecl_timer.sv */
// level duration counter, saturating, restarts on level change
`timescale 1ns/10ps
`include "ecl_cfg.svh"
module ecl_timer
  import ecl_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic restart,
  output logic [`ECL_CNT_W-1:0] count
);
  logic [`ECL_CNT_W-1:0] cnt_reg;
  logic [`ECL_CNT_W-1:0] cnt_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    if (ce)
    begin
      if (restart)
        cnt_next = '0;
      else if (cnt_reg != {`ECL_CNT_W{1'b1}})
        cnt_next = cnt_reg + `ECL_CNT_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

  assign count = cnt_reg;
endmodule

/* test/ecl_host.sv */
// host model that drives the single control pin
`timescale 1ns/10ps
module ecl_host
(
  input wire logic mclk,
  output logic pin
);
  initial pin = 1'b0;
  // hold the pin at one level for n cycles
  task automatic hold(input logic lvl, input int n);
    @(posedge mclk);
    #1 pin = lvl;
    repeat (n - 1) @(posedge mclk);
  endtask
  // edge burst at a 1 MHz rate, low pulses of 0.5 us
  task automatic burst(input int n);
    for (int i = 0; i < n; i++)
    begin
      hold(1'b0, 50);
      hold(1'b1, 50);
    end
  endtask
endmodule

/* test/edge_count_led_current_control_tb.sv */
// self-checking bench for the led current step and pwm control
`timescale 1ns/10ps
`include "ecl_cfg.svh"
module edge_count_led_current_control_tb;
  import ecl_pkg::*;
  localparam int LAT = 400;
  localparam int PWM_OFF = 800;
  logic mclk;
  logic nrst;
  logic ce;
  logic supply_low;
  logic s_pin;
  logic p_pin;
  logic [`ECL_STEP_W-1:0] step [4];
  logic [`ECL_SINKS-1:0] sink [4];
  logic pump [4];
  logic act [4];
  int err_count = 0;
  int n_compared = 0;
  int seed = 32'hd33d;
  int prev [3];
  int n;
  // ****************************************
  // one instance per variant, serial share a pin
  // ****************************************
  for (genvar g = 0; g < 4; g++)
  begin : gv
    ecl_ctrl #(.VARIANT(ecl_variant_e'(g)), .LAT_CYC(LAT), .OFF_CYC(LAT), .PWM_OFF_CYC(PWM_OFF)) u_ecl_ctrl (
      .mclk(mclk), .nrst(nrst), .ce(ce), .ctrl_pin(g == 3 ? p_pin : s_pin), .supply_low(supply_low),
      .step_code(step[g]), .led_sink_outputs(sink[g]), .pump_2x(pump[g]), .active(act[g]));
  end
  ecl_host u_ecl_host (.mclk(mclk), .pin(s_pin));
  ecl_host u_ecl_host_pwm (.mclk(mclk), .pin(p_pin));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic int exp_step(input int cnt, input int g);
    int lv;
    lv = (g == 0) ? 16 : (g == 1) ? 8 : 4;
    return (cnt > lv) ? lv : cnt;
  endfunction
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic write_check(input int cnt);
    u_ecl_host.burst(cnt);
    for (int g = 0; g < 3; g++)
    begin
      chk("step before latch", 8'(step[g]), 8'(prev[g]));
      chk("active", 8'(act[g]), 8'h01);
    end
    u_ecl_host.hold(1'b1, LAT + 10);
    for (int g = 0; g < 3; g++)
    begin
      prev[g] = exp_step(cnt, g);
      chk("step_code", 8'(step[g]), 8'(prev[g]));
      chk("led_sink_outputs", 8'(sink[g]), 8'h07);
    end
    $display("test write %0d done", cnt);
  endtask
  initial
  begin
    #900000;
    err_count++;
    stop_test();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    supply_low = 1'b0;
    prev = '{1, 1, 1};
    repeat (16) @(posedge mclk);
    #1 nrst = 1'b1;
    for (int g = 0; g < 4; g++)
      chk("reset outputs", {step[g], sink[g]}, 8'h00);
    $display("test reset done");
    foreach (prev[i])
      write_check(i == 0 ? 1 : i == 1 ? 17 : 9);
    write_check(16);
    write_check(5);
    write_check(8);
    repeat (6)
    begin
      n = ($unsigned($random(seed)) % 20) + 1;
      write_check(n);
    end
    u_ecl_host.hold(1'b0, LAT + 10);
    for (int g = 0; g < 3; g++)
    begin
      chk("shutdown", {step[g], sink[g]}, 8'h00);
      chk("shutdown active", 8'(act[g]), 8'h00);
    end
    $display("test shutdown done");
    prev = '{1, 1, 1};
    write_check(3);
    #1 supply_low = 1'b1;
    repeat (5) @(posedge mclk);
    for (int g = 0; g < 3; g++)
      chk("pump on", 8'(pump[g]), 8'h01);
    #1 supply_low = 1'b0;
    repeat (5) @(posedge mclk);
    for (int g = 0; g < 3; g++)
      chk("pump back", 8'(pump[g]), 8'h00);
    $display("test serial pump done");
    #1 ce = 1'b0;
    u_ecl_host.burst(2);
    #1 ce = 1'b1;
    u_ecl_host.hold(1'b1, LAT + 10);
    for (int g = 0; g < 3; g++)
      chk("frozen step", 8'(step[g]), 8'(exp_step(3, g)));
    $display("test clock enable done");
    u_ecl_host_pwm.hold(1'b1, 150);
    chk("pwm sinks early", 8'(sink[3]), 8'h00);
    chk("pwm active", 8'(act[3]), 8'h01);
    u_ecl_host_pwm.hold(1'b1, 100);
    chk("pwm sinks on", 8'(sink[3]), 8'h07);
    chk("pwm step", 8'(step[3]), 8'h01);
    #1 supply_low = 1'b1;
    repeat (5) @(posedge mclk);
    #1 supply_low = 1'b0;
    u_ecl_host_pwm.hold(1'b0, 20);
    chk("pwm sinks off", 8'(sink[3]), 8'h00);
    chk("pwm pump held", {7'h00, pump[3]}, 8'h01);
    chk("pwm still on", 8'(act[3]), 8'h01);
    u_ecl_host_pwm.hold(1'b0, PWM_OFF);
    chk("pwm shutdown", {6'h00, act[3], pump[3]}, 8'h00);
    $display("test pwm done");
    stop_test();
  end
endmodule
